// ### common/pdld_pkg.sv
// constants and types shared by the divider paths and lock detectors
package pdld_pkg;

    // operating modes of the clock conditioner
    typedef enum logic [2:0] {
        PDLD_DUAL_INT,
        PDLD_DUAL_INT_ZD,
        PDLD_DUAL_EXT,
        PDLD_DUAL_EXT_ZD,
        PDLD_SINGLE_INT,
        PDLD_SINGLE_INT_ZD,
        PDLD_SINGLE_EXT
    } pdld_mode_t;

    // lock detector sequencing
    typedef enum logic [1:0] {
        PDLD_LD_IDLE,
        PDLD_LD_WAIT_FB,
        PDLD_LD_WAIT_REF
    } pdld_ld_state_t;

    // field widths
    localparam int PDLD_PRE_W   = 8;
    localparam int PDLD_L1R_W   = 14;
    localparam int PDLD_L1N_W   = 14;
    localparam int PDLD_OSCD_W  = 3;
    localparam int PDLD_VCOD_W  = 3;
    localparam int PDLD_OUTD_W  = 11;
    localparam int PDLD_L2P_W   = 4;
    localparam int PDLD_L2N_W   = 19;
    localparam int PDLD_L2R_W   = 12;
    localparam int PDLD_WND_W   = 8;
    localparam int PDLD_CNT_W   = 18;
    localparam int PDLD_DIV_W   = 19;

    // documented divide ranges
    localparam logic [PDLD_L2P_W-1:0] PDLD_L2P_MIN = 4'h2;
    localparam logic [PDLD_L2P_W-1:0] PDLD_L2P_MAX = 4'h8;
    localparam logic [PDLD_L2N_W-1:0] PDLD_L2N_MIN = 19'h0_0001;
    localparam logic [PDLD_L2N_W-1:0] PDLD_L2N_MAX = 19'h4_03E7;

    // divider chain stage indices
    localparam int PDLD_ST_PRE   = 0;
    localparam int PDLD_ST_L1R   = 1;
    localparam int PDLD_ST_OSCD  = 2;
    localparam int PDLD_ST_L1N   = 3;
    localparam int PDLD_ST_VCOD  = 4;
    localparam int PDLD_ST_OUTD  = 5;
    localparam int PDLD_ST_L2P   = 6;
    localparam int PDLD_ST_L2N   = 7;
    localparam int PDLD_ST_L2R   = 8;
    localparam int PDLD_N_STAGES = 9;

    // reset values
    localparam logic [PDLD_DIV_W-1:0] PDLD_CNT_RST  = 19'h0_0000;
    localparam logic [PDLD_DIV_W-1:0] PDLD_DIV_ONE  = 19'h0_0001;
    localparam logic [PDLD_CNT_W-1:0] PDLD_LCNT_RST = 18'h0_0000;
    localparam logic [PDLD_CNT_W-1:0] PDLD_LCNT_ONE = 18'h0_0001;
    localparam logic [PDLD_WND_W-1:0] PDLD_SEP_RST  = 8'h00;
    localparam logic [PDLD_WND_W-1:0] PDLD_SEP_ONE  = 8'h01;

endpackage : pdld_pkg

// ### common/pdld_ldet_if.sv
// phase detector edges, lock settings and lock results of one detector
`timescale 1ns/1ps
interface pdld_ldet_if;
    import pdld_pkg::*;
    logic                  ref_pulse;
    logic                  fb_pulse;
    logic [PDLD_WND_W-1:0] window;
    logic [PDLD_CNT_W-1:0] count;
    logic                  locked;
    logic                  event_pulse;

    modport det (
        input  ref_pulse,
        input  fb_pulse,
        input  window,
        input  count,
        output locked,
        output event_pulse
    );
    modport ctl (
        output ref_pulse,
        output fb_pulse,
        output window,
        output count,
        input  locked,
        input  event_pulse
    );
endinterface : pdld_ldet_if

// ### hw/pdld_lock_det.sv
// digital lock detector for one event: window check and qualifying count
`timescale 1ns/1ps
module pdld_lock_det
    import pdld_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    // detector port
    pdld_ldet_if.det  ld
);

    pdld_ld_state_t        state;
    logic [PDLD_WND_W-1:0] sep;
    logic [PDLD_CNT_W-1:0] good_cnt;
    logic                  good;
    logic                  bad;
    logic                  next_locked;

    // one comparison per phase detector cycle; separation within window is good
    always_comb begin
        good = 1'b0;
        bad  = 1'b0;
        case (state)
            PDLD_LD_IDLE: begin
                good = ld.ref_pulse && ld.fb_pulse;
            end
            PDLD_LD_WAIT_FB: begin
                good = ld.fb_pulse && (sep < ld.window);
                bad  = (ld.ref_pulse && !ld.fb_pulse) || (!ld.fb_pulse && sep >= ld.window);
            end
            PDLD_LD_WAIT_REF: begin
                good = ld.ref_pulse && (sep < ld.window);
                bad  = (ld.fb_pulse && !ld.ref_pulse) || (!ld.ref_pulse && sep >= ld.window);
            end
            default: begin
                bad = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= PDLD_LD_IDLE;
            sep   <= PDLD_SEP_RST;
        end else if (good) begin
            state <= PDLD_LD_IDLE;
            sep   <= PDLD_SEP_RST;
        end else if (state == PDLD_LD_IDLE || bad) begin
            // a doubled edge restarts the pairing from the new edge; a timeout without one returns to idle
            sep <= PDLD_SEP_RST;
            if (ld.ref_pulse) begin
                state <= PDLD_LD_WAIT_FB;
            end else if (ld.fb_pulse) begin
                state <= PDLD_LD_WAIT_REF;
            end else begin
                state <= PDLD_LD_IDLE;
            end
        end else begin
            sep <= sep + PDLD_SEP_ONE;
        end
    end

    // saturate so a long lock never wraps into a false restart
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            good_cnt <= PDLD_LCNT_RST;
        end else if (bad) begin
            good_cnt <= PDLD_LCNT_RST;
        end else if (good && good_cnt != {PDLD_CNT_W{1'b1}}) begin
            good_cnt <= good_cnt + PDLD_LCNT_ONE;
        end
    end

    // lock needs count good cycles, never sooner than count pd periods
    assign next_locked = !bad && good && ((good_cnt + PDLD_LCNT_ONE) >= ld.count);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ld.locked      <= 1'b0;
            ld.event_pulse <= 1'b0;
        end else begin
            ld.event_pulse <= next_locked && !ld.locked;
            if (bad) begin
                ld.locked <= 1'b0;
            end else if (next_locked) begin
                ld.locked <= 1'b1;
            end
        end
    end

endmodule : pdld_lock_det

// ### hw/pdld_top.sv
// divider path selection for both loops and the three lock detectors
`timescale 1ns/1ps
module pdld_top
    import pdld_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   arst_n_i,
    // source clocks, sampled as levels
    input  wire logic                   clkin_i,
    input  wire logic                   osc_in_i,
    input  wire logic                   vco_i,
    // mode and path selection
    input  wire pdld_mode_t             mode_i,
    input  wire logic                   osc_output_path_i,
    input  wire logic                   vco_path_select_i,
    input  wire logic                   loop2_ref_doubler_en_i,
    input  wire logic                   vco_cal_active_i,
    // divider settings
    input  wire logic [PDLD_PRE_W-1:0]  input_prescaler_div_i,
    input  wire logic [PDLD_L1R_W-1:0]  loop1_ref_div_i,
    input  wire logic [PDLD_L1N_W-1:0]  loop1_fb_div_i,
    input  wire logic [PDLD_OSCD_W-1:0] osc_in_a_i,
    input  wire logic [PDLD_VCOD_W-1:0] vco_post_div_i,
    input  wire logic [PDLD_OUTD_W-1:0] output_channel_div_i,
    input  wire logic [PDLD_L2R_W-1:0]  loop2_ref_div_i,
    input  wire logic [PDLD_L2P_W-1:0]  loop2_fb_prescaler_i,
    input  wire logic [PDLD_L2N_W-1:0]  loop2_fb_div_i,
    input  wire logic [PDLD_L2N_W-1:0]  loop2_cal_fb_div_i,
    // lock detect settings
    input  wire logic [PDLD_WND_W-1:0]  loop1_lock_window_i,
    input  wire logic [PDLD_CNT_W-1:0]  loop1_lock_count_i,
    input  wire logic [PDLD_WND_W-1:0]  loop2_lock_window_i,
    input  wire logic [PDLD_CNT_W-1:0]  loop2_lock_count_i,
    input  wire logic [PDLD_CNT_W-1:0]  holdover_exit_count_i,
    // holdover control
    input  wire logic                   holdover_enter_i,
    // phase detector inputs
    output logic                        loop1_pd_ref_o,
    output logic                        loop1_pd_fb_o,
    output logic                        loop2_pd_ref_o,
    output logic                        loop2_pd_fb_o,
    // lock status
    output logic                        loop1_locked_o,
    output logic                        loop2_locked_o,
    output logic                        loop1_lock_event_o,
    output logic                        loop2_lock_event_o,
    output logic                        holdover_exit_event_o,
    output logic                        in_holdover_o,
    output logic                        settings_err_o
);

    logic                  clkin_q;
    logic                  osc_q;
    logic                  vco_q;
    logic                  clkin_rise;
    logic                  osc_rise;
    logic                  osc_edge;
    logic                  vco_rise;
    logic                  ext_vco;
    logic                  zero_delay_dual;
    logic                  single_zd;
    logic                  cal_path;
    logic                  vco_src;

    logic [PDLD_DIV_W-1:0] st_cnt [PDLD_N_STAGES];
    logic [PDLD_DIV_W-1:0] st_div [PDLD_N_STAGES];
    logic                  st_in  [PDLD_N_STAGES];
    logic                  st_out [PDLD_N_STAGES];

    pdld_ldet_if ld1 ();
    pdld_ldet_if ld2 ();
    pdld_ldet_if ldh ();

    // edge detection on the sampled source levels
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clkin_q <= 1'b0;
            osc_q   <= 1'b0;
            vco_q   <= 1'b0;
        end else begin
            clkin_q <= clkin_i;
            osc_q   <= osc_in_i;
            vco_q   <= vco_i;
        end
    end

    assign clkin_rise = clkin_i && !clkin_q;
    assign osc_rise   = osc_in_i && !osc_q;
    assign vco_rise   = vco_i && !vco_q;
    // doubling uses both osc edges, twice the rising-edge rate
    assign osc_edge   = loop2_ref_doubler_en_i ? (osc_in_i ^ osc_q) : osc_rise;

    // mode decode
    assign ext_vco         = (mode_i == PDLD_DUAL_EXT) || (mode_i == PDLD_DUAL_EXT_ZD)
                             || (mode_i == PDLD_SINGLE_EXT);
    assign zero_delay_dual = (mode_i == PDLD_DUAL_INT_ZD) || (mode_i == PDLD_DUAL_EXT_ZD);
    assign single_zd       = (mode_i == PDLD_SINGLE_INT_ZD);
    assign cal_path        = vco_cal_active_i && !ext_vco;
    // post divider only exists in the internal vco path
    assign vco_src         = (!ext_vco && vco_path_select_i) ? st_out[PDLD_ST_VCOD]
                                                              : vco_rise;

    // stage inputs and divide values of the divider chains
    always_comb begin
        st_in[PDLD_ST_PRE]  = clkin_rise;
        st_div[PDLD_ST_PRE] = PDLD_DIV_W'(input_prescaler_div_i);
        st_in[PDLD_ST_L1R]  = st_out[PDLD_ST_PRE];
        st_div[PDLD_ST_L1R] = PDLD_DIV_W'(loop1_ref_div_i);

        st_in[PDLD_ST_OSCD]  = osc_rise;
        st_div[PDLD_ST_OSCD] = PDLD_DIV_W'(osc_in_a_i);
        st_in[PDLD_ST_L1N]   = zero_delay_dual ? st_out[PDLD_ST_OUTD]
                             : (osc_output_path_i ? st_out[PDLD_ST_OSCD]
                                                  : osc_rise);
        st_div[PDLD_ST_L1N]  = PDLD_DIV_W'(loop1_fb_div_i);

        st_in[PDLD_ST_VCOD]  = vco_rise;
        st_div[PDLD_ST_VCOD] = PDLD_DIV_W'(vco_post_div_i);
        st_in[PDLD_ST_OUTD]  = vco_src;
        st_div[PDLD_ST_OUTD] = PDLD_DIV_W'(output_channel_div_i);

        st_in[PDLD_ST_L2P]   = vco_src;
        st_div[PDLD_ST_L2P]  = PDLD_DIV_W'(loop2_fb_prescaler_i);
        if (cal_path) begin
            st_in[PDLD_ST_L2N]  = st_out[PDLD_ST_L2P];
            st_div[PDLD_ST_L2N] = loop2_cal_fb_div_i;
        end else if (single_zd) begin
            st_in[PDLD_ST_L2N]  = st_out[PDLD_ST_OUTD];
            st_div[PDLD_ST_L2N] = loop2_fb_div_i;
        end else begin
            st_in[PDLD_ST_L2N]  = st_out[PDLD_ST_L2P];
            st_div[PDLD_ST_L2N] = loop2_fb_div_i;
        end

        st_in[PDLD_ST_L2R]   = osc_edge;
        st_div[PDLD_ST_L2R]  = PDLD_DIV_W'(loop2_ref_div_i);
    end

    // every stage counts input pulses and emits one per divide value;
    // a value of zero behaves as divide by one rather than stalling
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < PDLD_N_STAGES; i++) begin
                st_cnt[i] <= PDLD_CNT_RST;
                st_out[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < PDLD_N_STAGES; i++) begin
                if (!st_in[i]) begin
                    st_out[i] <= 1'b0;
                end else if ((st_cnt[i] + PDLD_DIV_ONE) >= st_div[i]) begin
                    st_cnt[i] <= PDLD_CNT_RST;
                    st_out[i] <= 1'b1;
                end else begin
                    st_cnt[i] <= st_cnt[i] + PDLD_DIV_ONE;
                    st_out[i] <= 1'b0;
                end
            end
        end
    end

    // phase detector edges, registered once more for clean outputs
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loop1_pd_ref_o <= 1'b0;
            loop1_pd_fb_o  <= 1'b0;
            loop2_pd_ref_o <= 1'b0;
            loop2_pd_fb_o  <= 1'b0;
        end else begin
            loop1_pd_ref_o <= st_out[PDLD_ST_L1R];
            loop1_pd_fb_o  <= st_out[PDLD_ST_L1N];
            loop2_pd_ref_o <= st_out[PDLD_ST_L2R];
            loop2_pd_fb_o  <= st_out[PDLD_ST_L2N];
        end
    end

    // out-of-range loop2 prescaler and loop2_fb_div_i flagged; the chain still runs
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settings_err_o <= 1'b0;
        end else begin
            settings_err_o <= (loop2_fb_prescaler_i < PDLD_L2P_MIN)
                              || (loop2_fb_prescaler_i > PDLD_L2P_MAX)
                              || (loop2_fb_div_i < PDLD_L2N_MIN)
                              || (loop2_fb_div_i > PDLD_L2N_MAX);
        end
    end

    // detector wiring: loop1 window shared by loop1 lock and holdover exit
    assign ld1.ref_pulse = st_out[PDLD_ST_L1R];
    assign ld1.fb_pulse  = st_out[PDLD_ST_L1N];
    assign ld1.window    = loop1_lock_window_i;
    assign ld1.count     = loop1_lock_count_i;
    assign ld2.ref_pulse = st_out[PDLD_ST_L2R];
    assign ld2.fb_pulse  = st_out[PDLD_ST_L2N];
    assign ld2.window    = loop2_lock_window_i;
    assign ld2.count     = loop2_lock_count_i;
    assign ldh.ref_pulse = st_out[PDLD_ST_L1R];
    assign ldh.fb_pulse  = st_out[PDLD_ST_L1N];
    assign ldh.window    = loop1_lock_window_i;
    assign ldh.count     = holdover_exit_count_i;

    pdld_lock_det u_ld1 (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .ld        (ld1.det)
    );

    pdld_lock_det u_ld2 (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .ld        (ld2.det)
    );

    pdld_lock_det u_ldh (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .ld        (ldh.det)
    );

    // lock indications and holdover exit event
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loop1_locked_o        <= 1'b0;
            loop2_locked_o        <= 1'b0;
            loop1_lock_event_o    <= 1'b0;
            loop2_lock_event_o    <= 1'b0;
            holdover_exit_event_o <= 1'b0;
        end else begin
            loop1_locked_o        <= ld1.locked;
            loop2_locked_o        <= ld2.locked;
            loop1_lock_event_o    <= ld1.event_pulse;
            loop2_lock_event_o    <= ld2.event_pulse;
            holdover_exit_event_o <= ldh.event_pulse && in_holdover_o;
        end
    end

    // exit only counts while in holdover; an entry request in the same cycle wins
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_holdover_o <= 1'b0;
        end else if (holdover_enter_i) begin
            in_holdover_o <= 1'b1;
        end else if (ldh.event_pulse) begin
            in_holdover_o <= 1'b0;
        end
    end

endmodule : pdld_top

// ### sim/pdld_src_model.sv
// source clock model: reference, oscillator and vco levels
`timescale 1ns/1ps
module pdld_src_model (
    // clock and reset
    input  wire logic            sys_clk_i,
    input  wire logic            arst_n_i,
    // half periods in system cycles, 0 ref, 1 osc, 2 vco
    input  wire logic [2:0][3:0] half_i,
    // source levels
    output logic      [2:0]      src_o
);
    logic [2:0][3:0] cnt;

    // updates on the falling edge so the design samples settled levels
    always_ff @(negedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt   <= '0;
            src_o <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (cnt[i] + 4'h1 >= half_i[i]) begin
                    cnt[i]   <= 4'h0;
                    src_o[i] <= !src_o[i];
                end else begin
                    cnt[i] <= cnt[i] + 4'h1;
                end
            end
        end
    end
endmodule : pdld_src_model

// ### sim/pdld_top_sva.sv
// concurrent checks on the top module ports
`timescale 1ns/1ps
module pdld_top_sva
    import pdld_pkg::*;
(
    // clock and reset
    input wire logic                  sys_clk_i,
    input wire logic                  arst_n_i,
    // watched inputs
    input wire logic                  holdover_enter_i,
    input wire logic [PDLD_L2P_W-1:0] loop2_fb_prescaler_i,
    input wire logic [PDLD_L2N_W-1:0] loop2_fb_div_i,
    input wire logic [PDLD_CNT_W-1:0] loop2_lock_count_i,
    // watched outputs
    input wire logic                  loop1_pd_ref_o,
    input wire logic                  loop1_pd_fb_o,
    input wire logic                  loop2_pd_ref_o,
    input wire logic                  loop1_locked_o,
    input wire logic                  loop2_locked_o,
    input wire logic                  loop1_lock_event_o,
    input wire logic                  loop2_lock_event_o,
    input wire logic                  holdover_exit_event_o,
    input wire logic                  in_holdover_o,
    input wire logic                  settings_err_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    logic [19:0] ref_seen;
    logic        bad_set;
    assign bad_set = (loop2_fb_prescaler_i < PDLD_L2P_MIN) || (loop2_fb_div_i < PDLD_L2N_MIN)
                     || (loop2_fb_div_i > PDLD_L2N_MAX) || (loop2_fb_prescaler_i > PDLD_L2P_MAX);

    // ref pulses since lock was last lost; held at zero while locked
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_seen <= '0;
        end else if (loop2_locked_o) begin
            ref_seen <= '0;
        end else if (loop2_pd_ref_o) begin
            ref_seen <= ref_seen + 20'h0_0001;
        end
    end

    sequence s_quiet;
        !holdover_enter_i [*3];
    endsequence
    sequence s_exit;
        holdover_exit_event_o ##0 s_quiet;
    endsequence

    a_l1_event_rise: assert property (loop1_lock_event_o == $rose(loop1_locked_o))
        else $error("loop1 event and lock rise differ");
    a_l2_event_rise: assert property (loop2_lock_event_o == $rose(loop2_locked_o))
        else $error("loop2 event and lock rise differ");
    a_exit_gated: assert property (holdover_exit_event_o |-> in_holdover_o || $past(in_holdover_o))
        else $error("exit event outside holdover");
    a_exit_leaves: assert property (s_exit |-> !in_holdover_o)
        else $error("holdover kept after exit event");
    a_enter_sets: assert property (holdover_enter_i |=> in_holdover_o)
        else $error("holdover not entered");
    a_pd1_ref_space: assert property (loop1_pd_ref_o |=> !loop1_pd_ref_o)
        else $error("loop1 ref pulses too close");
    a_pd1_fb_space: assert property (loop1_pd_fb_o |=> !loop1_pd_fb_o)
        else $error("loop1 fb pulses too close");
    a_lock_min_time: assert property ($rose(loop2_locked_o) && loop2_lock_count_i != '0
        |-> ref_seen + 20'h0_0001 >= {2'b00, loop2_lock_count_i})
        else $error("loop2 locked too early");
    a_err_flag_set: assert property (1'b1 |=> settings_err_o == $past(bad_set))
        else $error("settings flag wrong");
endmodule : pdld_top_sva

bind pdld_top pdld_top_sva u_pdld_top_sva (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .holdover_enter_i(holdover_enter_i),
    .loop2_fb_prescaler_i(loop2_fb_prescaler_i), .loop2_fb_div_i(loop2_fb_div_i),
    .loop2_lock_count_i(loop2_lock_count_i), .loop1_pd_ref_o(loop1_pd_ref_o),
    .loop1_pd_fb_o(loop1_pd_fb_o), .loop2_pd_ref_o(loop2_pd_ref_o),
    .loop1_locked_o(loop1_locked_o), .loop2_locked_o(loop2_locked_o),
    .loop1_lock_event_o(loop1_lock_event_o), .loop2_lock_event_o(loop2_lock_event_o),
    .holdover_exit_event_o(holdover_exit_event_o), .in_holdover_o(in_holdover_o),
    .settings_err_o(settings_err_o)
);

// ### sim/tb.sv
// self-checking bench: divider periods, settings flag, lock and holdover
`timescale 1ns/1ps
module tb;
    import pdld_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    logic [2:0] src;
    logic [3:0] pd;
    pdld_mode_t mode = PDLD_DUAL_INT;
    logic oph = 1'b0, vps = 1'b0, dbl = 1'b0, cal = 1'b0, hold = 1'b0;
    logic l1r, l1f, l2r, l2f, lk1, lk2, ev1, ev2, hev, inh, err;
    int hc = 2, ho = 2, hv = 2, pre = 1, r1 = 2, n1 = 2, od = 1, vd = 1, outd = 1;
    int r2 = 2, p = 2, n2 = 1, ncal = 1, w1 = 0, w2 = 0, c1 = 5, c2 = 5, ch = 4;
    int seed = 32'he559, cyc = 0, mismatches = 0, n_checks = 0, n0;
    int last[4], per[4], npul[4];
    int tp[7] = '{1, 2, 8, 2, 2, 0, 9};
    int tn[7] = '{1, 1, PDLD_L2N_MAX, PDLD_L2N_MAX + 1, 0, 5, 1};
    logic te[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    always #12.5 sys_clk_i = !sys_clk_i;

    pdld_src_model u_pdld_src_model (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .half_i({4'(hv), 4'(ho), 4'(hc)}), .src_o(src));

    pdld_top u_pdld_top (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clkin_i(src[0]),
        .osc_in_i(src[1]), .vco_i(src[2]), .mode_i(mode), .osc_output_path_i(oph),
        .vco_path_select_i(vps), .loop2_ref_doubler_en_i(dbl), .vco_cal_active_i(cal),
        .input_prescaler_div_i(PDLD_PRE_W'(pre)), .loop1_ref_div_i(PDLD_L1R_W'(r1)),
        .loop1_fb_div_i(PDLD_L1N_W'(n1)), .osc_in_a_i(PDLD_OSCD_W'(od)),
        .vco_post_div_i(PDLD_VCOD_W'(vd)), .output_channel_div_i(PDLD_OUTD_W'(outd)),
        .loop2_ref_div_i(PDLD_L2R_W'(r2)), .loop2_fb_prescaler_i(PDLD_L2P_W'(p)),
        .loop2_fb_div_i(PDLD_L2N_W'(n2)), .loop2_cal_fb_div_i(PDLD_L2N_W'(ncal)),
        .loop1_lock_window_i(PDLD_WND_W'(w1)), .loop1_lock_count_i(PDLD_CNT_W'(c1)),
        .loop2_lock_window_i(PDLD_WND_W'(w2)), .loop2_lock_count_i(PDLD_CNT_W'(c2)),
        .holdover_exit_count_i(PDLD_CNT_W'(ch)), .holdover_enter_i(hold),
        .loop1_pd_ref_o(l1r), .loop1_pd_fb_o(l1f), .loop2_pd_ref_o(l2r), .loop2_pd_fb_o(l2f),
        .loop1_locked_o(lk1), .loop2_locked_o(lk2), .loop1_lock_event_o(ev1),
        .loop2_lock_event_o(ev2), .holdover_exit_event_o(hev), .in_holdover_o(inh),
        .settings_err_o(err));

    assign pd = {l2f, l2r, l1f, l1r};

    // pulse spacing of each phase detector output
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++) begin
            if (pd[i] === 1'b1) begin
                per[i]  <= cyc - last[i];
                last[i] <= cyc;
                npul[i] <= npul[i] + 1;
            end
        end
        if (cyc == 80000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    function automatic int rr(input int lo, input int hi);
        return lo + $unsigned($random(seed)) % (hi - lo + 1);
    endfunction : rr

    // expected period in system cycles, -1 for loop1 fb outside PDLD_DUAL_INT and the two dual zero-delay modes
    function automatic int expp(input int i);
        int pv;
        logic intl;
        intl = mode inside {PDLD_DUAL_INT, PDLD_DUAL_INT_ZD, PDLD_SINGLE_INT, PDLD_SINGLE_INT_ZD};
        pv = (vps && intl) ? vd : 1;
        case (i)
            0: return 2 * hc * pre * r1;
            1: begin
                if (mode == PDLD_DUAL_INT) return 2 * ho * (oph ? od : 1) * n1;
                if (mode inside {PDLD_DUAL_INT_ZD, PDLD_DUAL_EXT_ZD}) return 2 * hv * pv * outd * n1;
                return -1;
            end
            2: return (dbl ? ho : 2 * ho) * r2;
            default: begin
                if (cal && intl) return 2 * hv * pv * p * ncal;
                if (mode == PDLD_SINGLE_INT_ZD) return 2 * hv * pv * outd * n2;
                return 2 * hv * pv * p * n2;
            end
        endcase
    endfunction : expp

    // skips four pulses so a change mid-count has flushed out
    task automatic chk_per(input int i);
        int e;
        int s;
        e = expp(i);
        s = npul[i];
        if (e < 0) return;
        for (int k = 0; k < 9000 && npul[i] < s + 4; k++) @(negedge sys_clk_i);
        chk(per[i] == e, "phase detector period");
    endtask : chk_per

    task automatic wt(input int s, input logic v, input int lim);
        for (int k = 0; k < lim && (s == 0 ? lk1 : s == 1 ? lk2 : inh) !== v; k++) begin
            @(negedge sys_clk_i);
        end
    endtask : wt

    task automatic rnd_cfg(input int m);
        @(negedge sys_clk_i);
        mode = pdld_mode_t'(m);
        hc = rr(1, 3);
        ho = rr(1, 3);
        hv = rr(1, 3);
        pre = rr(1, 3);
        r1 = rr(1, 3);
        n1 = rr(1, 3);
        od = rr(1, 3);
        vd = rr(1, 3);
        outd = rr(1, 3);
        p = (m == 0) ? 8 : (m == 1) ? 2 : rr(2, 8);
        n2 = rr(1, 3);
        ncal = rr(1, 3);
        {oph, vps, dbl, cal} = 4'($random(seed));
        r2 = dbl ? 2 : rr(2, 3);
    endtask : rnd_cfg

    initial begin
        repeat (5) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        for (int t = 0; t < 14; t++) begin
            rnd_cfg(t % 7);
            for (int i = 0; i < 4; i++) chk_per(i);
        end
        for (int k = 0; k < 7; k++) begin
            @(negedge sys_clk_i);
            p = tp[k];
            n2 = tn[k];
            repeat (2) @(negedge sys_clk_i);
            chk(err === te[k], "settings flag");
        end
        // second reset with matched 8-cycle loops and a wide window
        arst_n_i = 1'b0;
        mode = PDLD_DUAL_INT;
        {oph, vps, dbl, cal} = 4'h0;
        {hc, ho, hv, r1, n1, r2, p} = {7{32'h0000_0002}};
        {pre, n2} = {2{32'h0000_0001}};
        {w1, w2} = {2{32'h0000_0014}};
        repeat (2) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        n0 = npul[2];
        wt(1, 1'b1, 600);
        wt(0, 1'b1, 600);
        chk(lk1 === 1'b1 && lk2 === 1'b1, "lock missing");
        chk(npul[2] - n0 >= c2, "lock too early");
        hold = 1'b1;
        @(negedge sys_clk_i);
        hold = 1'b0;
        chk(inh === 1'b1, "holdover entry");
        n1 = 3;
        w1 = 0;
        wt(0, 1'b0, 400);
        chk(lk1 === 1'b0, "loop1 lock kept");
        chk(inh === 1'b1, "holdover left early");
        n1 = 2;
        w1 = 20;
        wt(2, 1'b0, 600);
        // holdover count is shorter, so loop1 lock follows one pd cycle later
        wt(0, 1'b1, 600);
        chk(inh === 1'b0 && lk1 === 1'b1, "holdover exit");
        n2 = 2;
        w2 = 0;
        wt(1, 1'b0, 400);
        chk(lk2 === 1'b0 && lk1 === 1'b1, "loop2 unlock");
        wrap_up();
    end
endmodule : tb
